// file: hdl/global_option_config_regs.sv
`timescale 1ns/1ns
module global_option_config_regs #(
  parameter int unsigned BLINK_HALF_CYCLES = gopt_pkg::LED_1HZ_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Power-on straps
  input  wire logic                      floppyDisableStrap,
  input  wire logic                      portSelectStrap,
  // Configuration I/O port
  input  wire logic                      ioWrite,
  input  wire logic                      ioRead,
  input  wire logic [15:0]               ioAddr,
  input  wire logic [7:0]                ioWrData,
  output logic      [7:0]                ioRdData,
  output logic                           ioRdValid,
  output logic                           configOpen,
  // Shared pins, floppy side
  input  wire logic [gopt_pkg::SHARED_PINS-1:0] floppyPadOut,
  input  wire logic [gopt_pkg::SHARED_PINS-1:0] floppyPadOe,
  output logic      [gopt_pkg::SHARED_PINS-1:0] floppyPadIn,
  // Shared pins, serial6 and GPIO6 side
  input  wire logic [gopt_pkg::SHARED_PINS-1:0] altPadOut,
  input  wire logic [gopt_pkg::SHARED_PINS-1:0] altPadOe,
  output logic      [gopt_pkg::SHARED_PINS-1:0] altPadIn,
  // Shared pins, package side
  input  wire logic [gopt_pkg::SHARED_PINS-1:0] padIn,
  output logic      [gopt_pkg::SHARED_PINS-1:0] padOut,
  output logic      [gopt_pkg::SHARED_PINS-1:0] padOe,
  // Unit controls
  output logic                           floppyEnabled,
  output logic                           floppyTristate,
  output logic                           parallelTristate,
  output logic                           serial1Tristate,
  output logic                           serial2Tristate,
  // Interrupt selection gating
  input  wire logic                      floppyDorBit3,
  input  wire logic                      parallelCtrlBit4,
  input  wire logic [gopt_pkg::SERIAL_PORTS-1:0] serialHandshakeBit3,
  output logic                           floppyIrqGate,
  output logic                           parallelIrqGate,
  output logic      [gopt_pkg::SERIAL_PORTS-1:0] serialIrqGate,
  // Parallel mode and GPIO drive type
  output logic      [2:0]                parallelMode,
  output logic                           parallelModeNormal,
  output logic      [3:0]                gpioPushPull,
  // Monitor alarm pin
  input  wire logic                      overtempAlarm_n,
  input  wire logic                      mgmtInterrupt_n,
  output logic                           alarmPin_n,
  // Power LED pin
  output logic                           powerLedOut,
  output logic                           powerLedOe
);

  typedef enum logic [1:0] {CFG_IDLE, CFG_KEY_SEEN, CFG_OPEN} cfg_state_t;

  // Refuse a blink divider the blinker cannot serve
  if (BLINK_HALF_CYCLES < 2) begin : g_bad_blink
    $error("global_option_config_regs: BLINK_HALF_CYCLES below 2");
  end

  cfg_state_t state;
  cfg_state_t next_state;
  logic [7:0] cfgIndex;
  logic       floppyDis;
  logic [7:0] tristateReg;
  logic [7:0] portLockReg;
  logic [7:0] serialPmodeReg;
  logic [7:0] outTypeReg;

  // Port decode follows the strapped, writable port select
  wire        portSel   = portLockReg[gopt_pkg::PORT_SEL_BIT];
  wire [15:0] indexPort = portSel ? gopt_pkg::PORT_BASE_HIGH
                                  : gopt_pkg::PORT_BASE_LOW;
  wire [15:0] dataPort  = indexPort + gopt_pkg::DATA_PORT_STEP;
  wire        hitIndex  = ioAddr == indexPort;
  wire        hitData   = ioAddr == dataPort;
  wire        isOpen    = state == CFG_OPEN;
  wire        keyWrite  = ioWrite & hitIndex
                          & (ioWrData == gopt_pkg::ENTRY_KEY);

  // Lock blocks every register but the one holding the lock
  wire        lockIdx   = cfgIndex == gopt_pkg::IDX_PORT_LOCK;
  wire        accessOk  = ~portLockReg[gopt_pkg::LOCK_BIT] | lockIdx;
  wire        regWrite  = ioWrite & hitData & isOpen & accessOk;
  wire        idxWrite  = ioWrite & hitIndex & isOpen;

  // Per-register write strobes
  wire wrStrap  = regWrite & (cfgIndex == gopt_pkg::IDX_FLOPPY_STRAP);
  wire wrTri    = regWrite & (cfgIndex == gopt_pkg::IDX_TRISTATE);
  wire wrLock   = regWrite & lockIdx;
  wire wrPmode  = regWrite & (cfgIndex == gopt_pkg::IDX_SERIAL_PMODE);
  wire wrOut    = regWrite & (cfgIndex == gopt_pkg::IDX_OUTTYPE_LED);

  // Masked next values; reserved bits never store
  wire [7:0] strapView = {6'h00, floppyDis, 1'b0};
  wire [7:0] next_strapView =
    (strapView & ~gopt_pkg::MASK_FLOPPY_STRAP)
    | (ioWrData & gopt_pkg::MASK_FLOPPY_STRAP);
  wire [7:0] next_tristate =
    (tristateReg & ~gopt_pkg::MASK_TRISTATE)
    | (ioWrData & gopt_pkg::MASK_TRISTATE);
  wire [7:0] next_portLock =
    (portLockReg & ~gopt_pkg::MASK_PORT_LOCK)
    | (ioWrData & gopt_pkg::MASK_PORT_LOCK);
  wire [7:0] next_serialPmode =
    (serialPmodeReg & ~gopt_pkg::MASK_SERIAL_PMODE)
    | (ioWrData & gopt_pkg::MASK_SERIAL_PMODE);
  wire [7:0] next_outType =
    (outTypeReg & ~gopt_pkg::MASK_OUTTYPE_LED)
    | (ioWrData & gopt_pkg::MASK_OUTTYPE_LED);

  // Read selection; reserved and unmapped indexes read zero
  wire [7:0] regValue =
    (cfgIndex == gopt_pkg::IDX_FLOPPY_STRAP) ? strapView :
    (cfgIndex == gopt_pkg::IDX_TRISTATE)     ? tristateReg :
    lockIdx                                  ? portLockReg :
    (cfgIndex == gopt_pkg::IDX_SERIAL_PMODE) ? serialPmodeReg :
    (cfgIndex == gopt_pkg::IDX_OUTTYPE_LED)  ? outTypeReg :
    8'h00;
  wire [7:0] dataRead   = accessOk ? regValue : 8'h00;
  wire [7:0] next_rdData = hitIndex ? cfgIndex : dataRead;
  wire       next_rdValid = ioRead & isOpen & (hitIndex | hitData);

  // Entry by double key, exit by exit key at the index port
  always_comb
  begin
    next_state = state;
    case (state)
      CFG_IDLE:
        if (keyWrite)
          next_state = CFG_KEY_SEEN;
      CFG_KEY_SEEN:
        if (ioWrite)
          next_state = keyWrite ? CFG_OPEN : CFG_IDLE;
      CFG_OPEN:
        if (idxWrite && ioWrData == gopt_pkg::EXIT_KEY)
          next_state = CFG_IDLE;
      default:
        next_state = CFG_IDLE;
    endcase
  end

  // Entry state and index
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= CFG_IDLE;
      cfgIndex <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      cfgIndex <= (idxWrite && ioWrData != gopt_pkg::EXIT_KEY)
                  ? ioWrData : cfgIndex;
    end
  end

  // Strapped registers; straps are taken while reset is held
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      floppyDis      <= floppyDisableStrap;
      portLockReg    <= gopt_pkg::RST_PORT_LOCK
                        | {1'b0, portSelectStrap, 6'h00};
    end
    else
    begin
      if (wrStrap)
        floppyDis <= next_strapView[gopt_pkg::FLOPPY_DIS_BIT];
      if (wrLock)
        portLockReg <= next_portLock;
    end
  end

  // Plain registers, reset to zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tristateReg    <= gopt_pkg::RST_TRISTATE;
      serialPmodeReg <= gopt_pkg::RST_SERIAL_PMODE;
      outTypeReg     <= gopt_pkg::RST_OUTTYPE_LED;
    end
    else
    begin
      if (wrTri)
        tristateReg <= next_tristate;
      if (wrPmode)
        serialPmodeReg <= next_serialPmode;
      if (wrOut)
        outTypeReg <= next_outType;
    end
  end

  // Read answer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ioRdData   <= 8'h00;
      ioRdValid  <= 1'b0;
      configOpen <= 1'b0;
    end
    else
    begin
      ioRdData   <= next_rdValid ? next_rdData : 8'h00;
      ioRdValid  <= next_rdValid;
      configOpen <= next_state == CFG_OPEN;
    end
  end

  // Shared pin routing; floppy tristate floats its own drive
  wire floppyOn = ~floppyDis;
  wire [gopt_pkg::SHARED_PINS-1:0] floppyOeGated =
    floppyPadOe & {gopt_pkg::SHARED_PINS{~tristateReg[
      gopt_pkg::TRI_FLOPPY_BIT]}};
  wire [gopt_pkg::SHARED_PINS-1:0] next_padOut =
    floppyOn ? floppyPadOut : altPadOut;
  wire [gopt_pkg::SHARED_PINS-1:0] next_padOe =
    floppyOn ? floppyOeGated : altPadOe;
  wire [gopt_pkg::SHARED_PINS-1:0] idlePins = {gopt_pkg::SHARED_PINS{1'b1}};
  wire [gopt_pkg::SHARED_PINS-1:0] next_floppyIn =
    floppyOn ? padIn : idlePins;
  wire [gopt_pkg::SHARED_PINS-1:0] next_altIn =
    floppyOn ? idlePins : padIn;

  // Serial legacy disables, serial1 first
  wire [gopt_pkg::SERIAL_PORTS-1:0] serialLegacyDis = {
    serialPmodeReg[gopt_pkg::LEG_SERIAL3_LSB +: 4],
    portLockReg[gopt_pkg::LEG_SERIAL2_BIT],
    portLockReg[gopt_pkg::LEG_SERIAL1_BIT]};
  wire [gopt_pkg::SERIAL_PORTS-1:0] next_serialGate;

  // Disabled legacy mode ignores the unit bit and passes
  for (genvar i = 0; i < gopt_pkg::SERIAL_PORTS; i++) begin : g_serial
    assign next_serialGate[i] = serialLegacyDis[i]
                                | serialHandshakeBit3[i];
  end
  wire next_floppyGate = portLockReg[gopt_pkg::LEG_FLOPPY_BIT]
                         | floppyDorBit3;
  wire next_parallelGate = portLockReg[gopt_pkg::LEG_PARALLEL_BIT]
                           | parallelCtrlBit4;

  // Output type and alarm routing
  wire [3:0] next_pushPull = {
    outTypeReg[gopt_pkg::GPIO6_TYPE_BIT],
    outTypeReg[gopt_pkg::GPIO5_TYPE_BIT],
    outTypeReg[gopt_pkg::GPIO4_TYPE_BIT],
    outTypeReg[gopt_pkg::GPIO3_TYPE_BIT]};
  wire next_alarm = outTypeReg[gopt_pkg::ALARM_SEL_BIT]
                    ? mgmtInterrupt_n : overtempAlarm_n;
  wire [2:0] pmode = serialPmodeReg[gopt_pkg::PMODE_LSB +: 3];

  // Shared pin flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      padOut        <= '0;
      padOe         <= '0;
      floppyPadIn   <= '1;
      altPadIn      <= '1;
      floppyEnabled <= 1'b0;
    end
    else
    begin
      padOut        <= next_padOut;
      padOe         <= next_padOe;
      floppyPadIn   <= next_floppyIn;
      altPadIn      <= next_altIn;
      floppyEnabled <= floppyOn;
    end
  end

  // Interface tristate flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      floppyTristate   <= 1'b0;
      parallelTristate <= 1'b0;
      serial1Tristate  <= 1'b0;
      serial2Tristate  <= 1'b0;
    end
    else
    begin
      floppyTristate   <= tristateReg[gopt_pkg::TRI_FLOPPY_BIT];
      parallelTristate <= tristateReg[gopt_pkg::TRI_PARALLEL_BIT];
      serial1Tristate  <= tristateReg[gopt_pkg::TRI_SERIAL1_BIT];
      serial2Tristate  <= tristateReg[gopt_pkg::TRI_SERIAL2_BIT];
    end
  end

  // Interrupt selection gate flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      floppyIrqGate   <= 1'b0;
      parallelIrqGate <= 1'b0;
      serialIrqGate   <= '0;
    end
    else
    begin
      floppyIrqGate   <= next_floppyGate;
      parallelIrqGate <= next_parallelGate;
      serialIrqGate   <= next_serialGate;
    end
  end

  // Mode, drive type and alarm flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      parallelMode       <= 3'h0;
      parallelModeNormal <= 1'b0;
      gpioPushPull       <= 4'h0;
      alarmPin_n         <= 1'b1;
    end
    else
    begin
      parallelMode       <= pmode;
      parallelModeNormal <= ~pmode[gopt_pkg::PMODE_TOP_BIT];
      gpioPushPull       <= next_pushPull;
      alarmPin_n         <= next_alarm;
    end
  end

  // Power LED blinker
  led_ctrl_if ledBus ();
  assign ledBus.mode = outTypeReg[gopt_pkg::LED_MODE_LSB +: 2];

  led_blinker #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blinker (
    .clk   (clk),
    .rst_n (rst_n),
    .led   (ledBus.blinker)
  );

  // LED pin comes straight from the blinker flops
  assign powerLedOut = ledBus.ledOut;
  assign powerLedOe  = ledBus.ledOe;

endmodule : global_option_config_regs

// file: hdl/gopt_pkg.sv
package gopt_pkg;

  // Configuration port pair and keys
  localparam logic [15:0] PORT_BASE_LOW   = 16'h002e;
  localparam logic [15:0] PORT_BASE_HIGH  = 16'h004e;
  localparam logic [15:0] DATA_PORT_STEP  = 16'h0001;
  localparam logic [7:0]  ENTRY_KEY       = 8'h87;
  localparam logic [7:0]  EXIT_KEY        = 8'haa;

  // Register indexes
  localparam logic [7:0]  IDX_FLOPPY_STRAP = 8'h24;
  localparam logic [7:0]  IDX_TRISTATE     = 8'h25;
  localparam logic [7:0]  IDX_PORT_LOCK    = 8'h26;
  localparam logic [7:0]  IDX_RSVD_27      = 8'h27;
  localparam logic [7:0]  IDX_SERIAL_PMODE = 8'h28;
  localparam logic [7:0]  IDX_OUTTYPE_LED  = 8'h29;

  // Writable bits; everything else reads zero
  localparam logic [7:0]  MASK_FLOPPY_STRAP = 8'h02;
  localparam logic [7:0]  MASK_TRISTATE     = 8'h39;
  localparam logic [7:0]  MASK_PORT_LOCK    = 8'h6f;
  localparam logic [7:0]  MASK_SERIAL_PMODE = 8'hf7;
  localparam logic [7:0]  MASK_OUTTYPE_LED  = 8'hfe;

  // Reset values, strapped bits excluded
  localparam logic [7:0]  RST_TRISTATE      = 8'h00;
  localparam logic [7:0]  RST_PORT_LOCK     = 8'h00;
  localparam logic [7:0]  RST_SERIAL_PMODE  = 8'h00;
  localparam logic [7:0]  RST_OUTTYPE_LED   = 8'h00;

  // Field positions
  localparam int FLOPPY_DIS_BIT   = 1;
  localparam int TRI_FLOPPY_BIT   = 0;
  localparam int TRI_PARALLEL_BIT = 3;
  localparam int TRI_SERIAL1_BIT  = 4;
  localparam int TRI_SERIAL2_BIT  = 5;
  localparam int PORT_SEL_BIT     = 6;
  localparam int LOCK_BIT         = 5;
  localparam int LEG_FLOPPY_BIT   = 3;
  localparam int LEG_PARALLEL_BIT = 2;
  localparam int LEG_SERIAL1_BIT  = 1;
  localparam int LEG_SERIAL2_BIT  = 0;
  localparam int LEG_SERIAL3_LSB  = 4;
  localparam int PMODE_LSB        = 0;
  localparam int PMODE_TOP_BIT    = 2;
  localparam int GPIO3_TYPE_BIT   = 3;
  localparam int GPIO4_TYPE_BIT   = 4;
  localparam int GPIO5_TYPE_BIT   = 5;
  localparam int GPIO6_TYPE_BIT   = 7;
  localparam int ALARM_SEL_BIT    = 6;
  localparam int LED_MODE_LSB     = 1;

  // Power LED modes
  localparam logic [1:0] LED_MODE_FLOAT   = 2'h0;
  localparam logic [1:0] LED_MODE_LOW     = 2'h1;
  localparam logic [1:0] LED_MODE_1HZ     = 2'h2;
  localparam logic [1:0] LED_MODE_QUARTER = 2'h3;

  // Blink timing
  localparam int unsigned CLK_FREQ_HZ       = 250000000;
  localparam int unsigned LED_1HZ_HALF_MS   = 500;
  localparam int unsigned LED_1HZ_HALF_CYCLES =
    LED_1HZ_HALF_MS * (CLK_FREQ_HZ / 1000);
  localparam int FAST_PHASE_BIT    = 0;
  localparam int QUARTER_PHASE_BIT = 2;

  // Sizes
  localparam int SHARED_PINS  = 7;
  localparam int SERIAL_PORTS = 6;

endpackage : gopt_pkg

// file: hdl/led_blinker.sv
`timescale 1ns/1ns
module led_blinker #(
  parameter int unsigned HALF_CYCLES = gopt_pkg::LED_1HZ_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode and pin drive
  led_ctrl_if.blinker led
);

  localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  // Refuse a divider that cannot make a half period
  if (HALF_CYCLES < 2) begin : g_bad_half
    $error("led_blinker: HALF_CYCLES must be at least 2");
  end

  logic [CW-1:0] divCount;
  logic [2:0]    phaseCount;
  logic          next_ledOut;
  logic          next_ledOe;

  // Half-second tick from the device clock
  wire           tick          = divCount == LAST;
  wire [CW-1:0]  next_divCount = tick ? '0 : divCount + 1'b1;
  wire [2:0]     next_phase    = tick ? phaseCount + 3'h1 : phaseCount;

  // Pin drive per mode
  always_comb
  begin
    next_ledOut = 1'b0;
    next_ledOe  = 1'b0;
    case (led.mode)
      gopt_pkg::LED_MODE_FLOAT:
      begin
        next_ledOut = 1'b0;
        next_ledOe  = 1'b0;
      end
      gopt_pkg::LED_MODE_LOW:
      begin
        next_ledOut = 1'b0;
        next_ledOe  = 1'b1;
      end
      gopt_pkg::LED_MODE_1HZ:
      begin
        next_ledOut = next_phase[gopt_pkg::FAST_PHASE_BIT];
        next_ledOe  = 1'b1;
      end
      default:
      begin
        next_ledOut = next_phase[gopt_pkg::QUARTER_PHASE_BIT];
        next_ledOe  = 1'b1;
      end
    endcase
  end

  // Divider, phase and pin flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      divCount   <= '0;
      phaseCount <= 3'h0;
      led.ledOut <= 1'b0;
      led.ledOe  <= 1'b0;
    end
    else
    begin
      divCount   <= next_divCount;
      phaseCount <= next_phase;
      led.ledOut <= next_ledOut;
      led.ledOe  <= next_ledOe;
    end
  end

endmodule : led_blinker

// file: hdl/led_ctrl_if.sv
`timescale 1ns/1ns
// Mode from the register bank, pin drive back from the blinker
interface led_ctrl_if;
  logic [1:0] mode;
  logic       ledOut;
  logic       ledOe;

  modport ctrl    (output mode, input ledOut, input ledOe);
  modport blinker (input mode, output ledOut, output ledOe);
endinterface : led_ctrl_if

// file: sim/global_option_config_regs_monitor.sv
`timescale 1ns/1ns
module global_option_config_regs_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Configuration port
  input wire logic       ioWrite,
  input wire logic       ioRead,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic       ioRdValid,
  input wire logic       configOpen,
  // Shared pins
  input wire logic [6:0] padOe,
  input wire logic [6:0] floppyPadIn,
  input wire logic [6:0] altPadIn,
  input wire logic       floppyEnabled,
  input wire logic       floppyTristate,
  // Interrupt gating, mode, alarm
  input wire logic       floppyDorBit3,
  input wire logic       floppyIrqGate,
  input wire logic [5:0] serialHandshakeBit3,
  input wire logic [5:0] serialIrqGate,
  input wire logic [2:0] parallelMode,
  input wire logic       parallelModeNormal,
  input wire logic       overtempAlarm_n,
  input wire logic       mgmtInterrupt_n,
  input wire logic       alarmPin_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Any cycle that writes no key value, at any port
  sequence notKey;
    !ioWrite || ioWrData != 8'h87;
  endsequence

  // Config port answers
  rd_answer_a: assert property (ioRdValid |-> $past(ioRead))
    else $error("read answer without a read");
  rd_idle_a: assert property (!ioRdValid |-> ioRdData == 8'h00)
    else $error("read data not zero when idle");
  key_entry_a: assert property (notKey |=> !$rose(configOpen))
    else $error("config mode opened without key");
  // Interrupt selection gates
  floppy_gate_a: assert property (
    $past(rst_n) && $past(floppyDorBit3) |-> floppyIrqGate)
    else $error("floppy gate lost unit bit");
  serial_gate_a: assert property (
    $past(rst_n) |-> &(serialIrqGate | ~$past(serialHandshakeBit3)))
    else $error("serial gate lost unit bit");
  // Alarm pin routing and parallel normal flag
  alarm_route_a: assert property ($past(rst_n) &&
    $past(overtempAlarm_n) == $past(mgmtInterrupt_n)
    |-> alarmPin_n == $past(overtempAlarm_n))
    else $error("alarm pin not from a source");
  pmode_norm_a: assert property (
    $past(rst_n) |-> parallelModeNormal == !parallelMode[2])
    else $error("parallel normal flag wrong");
  // Shared pin steering
  pin_share_a: assert property ($past(rst_n) |->
    (floppyEnabled ? altPadIn : floppyPadIn) == 7'h7f)
    else $error("unselected pad input not high");
  fdc_float_a: assert property (
    floppyEnabled && floppyTristate |-> padOe == 7'h00)
    else $error("floppy pins driven while floated");
endmodule : global_option_config_regs_monitor

// file: sim/test_global_option_config_regs.sv
`timescale 1ns/1ns
module test_global_option_config_regs;
  logic        clk, rst_n, floppyDisableStrap, portSelectStrap;
  logic        ioWrite, ioRead, ioRdValid, configOpen;
  logic [15:0] ioAddr, base;
  logic [7:0]  ioWrData, ioRdData, rd, d, idx;
  logic [7:0]  g [5];
  logic [6:0]  floppyPadOut, floppyPadOe, floppyPadIn, altPadOut;
  logic [6:0]  altPadOe, altPadIn, padIn, padOut, padOe;
  logic        floppyEnabled, floppyTristate, parallelTristate;
  logic        serial1Tristate, serial2Tristate, floppyDorBit3;
  logic        parallelCtrlBit4, floppyIrqGate, parallelIrqGate;
  logic        parallelModeNormal, overtempAlarm_n, mgmtInterrupt_n;
  logic        alarmPin_n, powerLedOut, powerLedOe;
  logic [5:0]  serialHandshakeBit3, serialIrqGate;
  logic [2:0]  parallelMode;
  logic [3:0]  gpioPushPull, tri4;
  logic [31:0] r, seed = 32'h4;
  int          err_count = 0, checked = 0, cyc = 0, n;

  assign tri4 = {serial2Tristate, serial1Tristate, parallelTristate,
                 floppyTristate};

  global_option_config_regs #(.BLINK_HALF_CYCLES(4)) uut (
    .clk(clk), .rst_n(rst_n), .floppyDisableStrap(floppyDisableStrap),
    .portSelectStrap(portSelectStrap), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .configOpen(configOpen),
    .floppyPadOut(floppyPadOut), .floppyPadOe(floppyPadOe),
    .floppyPadIn(floppyPadIn), .altPadOut(altPadOut), .altPadOe(altPadOe),
    .altPadIn(altPadIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .floppyEnabled(floppyEnabled), .floppyTristate(floppyTristate),
    .parallelTristate(parallelTristate), .serial1Tristate(serial1Tristate),
    .serial2Tristate(serial2Tristate), .floppyDorBit3(floppyDorBit3),
    .parallelCtrlBit4(parallelCtrlBit4),
    .serialHandshakeBit3(serialHandshakeBit3),
    .floppyIrqGate(floppyIrqGate), .parallelIrqGate(parallelIrqGate),
    .serialIrqGate(serialIrqGate), .parallelMode(parallelMode),
    .parallelModeNormal(parallelModeNormal), .gpioPushPull(gpioPushPull),
    .overtempAlarm_n(overtempAlarm_n), .mgmtInterrupt_n(mgmtInterrupt_n),
    .alarmPin_n(alarmPin_n), .powerLedOut(powerLedOut),
    .powerLedOe(powerLedOe));

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Writable bits of each index from 25 to 29
  function automatic logic [7:0] mask(input logic [7:0] i);
    case (i)
      8'h25: return 8'h39;
      8'h26: return 8'h6f;
      8'h28: return 8'hf7;
      8'h29: return 8'hfe;
      default: return 8'h00;
    endcase
  endfunction : mask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Random levels on all unit and pin inputs
  task automatic shake();
    r = rnd();
    {floppyPadOut, floppyPadOe, altPadOut, altPadOe} = r[27:0];
    r = rnd();
    {padIn, serialHandshakeBit3, floppyDorBit3, parallelCtrlBit4,
     overtempAlarm_n, mgmtInterrupt_n} = r[16:0];
  endtask : shake

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    ioWrite = 1'b1;
    ioAddr = a;
    ioWrData = v;
    @(negedge clk);
    ioWrite = 1'b0;
  endtask : wr

  task automatic rdp(input logic [15:0] a, input logic v);
    @(negedge clk);
    ioRead = 1'b1;
    ioAddr = a;
    @(negedge clk);
    ioRead = 1'b0;
    rd = ioRdData;
    chk(ioRdValid, v);
  endtask : rdp

  task automatic regw(input logic [7:0] i, input logic [7:0] v);
    wr(base, i);
    wr(base + 16'h1, v);
    repeat (2) @(negedge clk);
  endtask : regw

  task automatic regr(input logic [7:0] i, input logic [7:0] e);
    wr(base, i);
    rdp(base + 16'h1, 1'b1);
    chk(rd, e);
  endtask : regr

  task automatic enter();
    wr(base, 8'h87);
    wr(base, 8'h87);
    @(negedge clk);
    chk(configOpen, 1'b1);
  endtask : enter

  task automatic doReset();
    rst_n = 1'b0;
    r = rnd();
    floppyDisableStrap = r[0];
    g = '{default: 8'h00};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    base = portSelectStrap ? 16'h004e : 16'h002e;
  endtask : doReset

  // Outputs against the shadow registers
  task automatic outs();
    chk(tri4, {g[0][5:3], g[0][0]});
    chk(floppyIrqGate, g[1][3] | floppyDorBit3);
    chk(parallelIrqGate, g[1][2] | parallelCtrlBit4);
    chk(serialIrqGate[0], g[1][1] | serialHandshakeBit3[0]);
    chk(serialIrqGate[1], g[1][0] | serialHandshakeBit3[1]);
    chk(serialIrqGate[5:2], g[3][7:4] | serialHandshakeBit3[5:2]);
    chk(parallelMode, g[3][2:0]);
    chk(parallelModeNormal, !g[3][2]);
    chk(gpioPushPull, {g[4][7], g[4][5:3]});
    chk(alarmPin_n, g[4][6] ? mgmtInterrupt_n : overtempAlarm_n);
  endtask : outs

  // Half period of the LED after one edge
  task automatic ledTime(output int c);
    logic v;
    for (int j = 0; j < 2; j++)
    begin
      v = powerLedOut;
      c = 0;
      while (c < 40 && powerLedOut === v)
      begin
        @(negedge clk);
        c++;
      end
    end
  endtask : ledTime

  initial
  begin
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = 16'h0000;
    ioWrData = 8'h00;
    portSelectStrap = 1'b0;
    shake();
    doReset();
    rdp(base + 16'h1, 1'b0);
    chk(floppyEnabled, !floppyDisableStrap);
    chk(parallelModeNormal, 1'b1);
    chk(serialIrqGate, serialHandshakeBit3);
    enter();
    regr(8'h24, {6'h00, floppyDisableStrap, 1'b0});
    for (int i = 0; i < 5; i++)
      regr(8'h25 + i[7:0], 8'h00);
    $display("reset test done");
    // Register writes, all-ones first except 9f at index 26
    for (int k = 0; k < 16; k++)
    begin
      shake();
      r = rnd();
      idx = k < 5 ? 8'h25 + k[7:0] : 8'h25 + {5'h00, r[10:8] % 3'h5};
      d = k < 5 ? 8'hff : r[7:0];
      if (idx == 8'h26)
        d = d & 8'h9f;
      regw(idx, d);
      g[idx - 8'h25] = d & mask(idx);
      regr(idx, g[idx - 8'h25]);
      outs();
    end
    $display("register test done");
    // Lock blocks other indexes
    regw(8'h25, 8'h39);
    regw(8'h26, 8'h20);
    regw(8'h25, 8'h00);
    regr(8'h25, 8'h00);
    regw(8'h26, 8'h00);
    regr(8'h25, 8'h39);
    g[0] = 8'h39;
    g[1] = 8'h00;
    outs();
    $display("lock test done");
    // Shared pins in both modes, then floppy float
    regw(8'h25, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      regw(8'h24, m ? 8'h02 : 8'h00);
      shake();
      repeat (2) @(negedge clk);
      chk(floppyEnabled, !m);
      chk(padOut, m ? altPadOut : floppyPadOut);
      chk(padOe, m ? altPadOe : floppyPadOe);
      chk(m ? altPadIn : floppyPadIn, padIn);
    end
    regw(8'h24, 8'h00);
    regw(8'h25, 8'h01);
    chk(padOe, 7'h00);
    $display("pin test done");
    // Power LED modes
    for (int m = 0; m < 4; m++)
    begin
      regw(8'h29, {5'h00, m[1:0], 1'b0});
      ledTime(n);
      chk(powerLedOe, m != 0);
      if (m == 1)
        chk(powerLedOut, 1'b0);
      if (m > 1)
        chk(n[15:0], m == 2 ? 16'h4 : 16'h10);
    end
    $display("led test done");
    // Exit, then strapped high port pair
    wr(base, 8'haa);
    @(negedge clk);
    chk(configOpen, 1'b0);
    portSelectStrap = 1'b1;
    doReset();
    wr(16'h002e, 8'h87);
    wr(16'h002e, 8'h87);
    @(negedge clk);
    chk(configOpen, 1'b0);
    enter();
    regr(8'h26, 8'h40);
    $display("port test done");
    end_sim();
  end
endmodule : test_global_option_config_regs

bind global_option_config_regs global_option_config_regs_monitor mon (
  .clk(clk), .rst_n(rst_n), .ioWrite(ioWrite), .ioRead(ioRead),
  .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
  .configOpen(configOpen), .padOe(padOe), .floppyPadIn(floppyPadIn),
  .altPadIn(altPadIn), .floppyEnabled(floppyEnabled),
  .floppyTristate(floppyTristate), .floppyDorBit3(floppyDorBit3),
  .floppyIrqGate(floppyIrqGate), .serialHandshakeBit3(serialHandshakeBit3),
  .serialIrqGate(serialIrqGate), .parallelMode(parallelMode),
  .parallelModeNormal(parallelModeNormal), .overtempAlarm_n(overtempAlarm_n),
  .mgmtInterrupt_n(mgmtInterrupt_n), .alarmPin_n(alarmPin_n));
